// ### testbench/crcscn_arb_model.sv
// Memory arbiter model: grants scanner fetches, one word per grant.
// Assumes it shares clk with the scanner.
module crcscn_arb_model
    import crcscn_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic stall,
    input wire crcscn_mreq_t mem_req,
    output crcscn_mrsp_t mem_rsp
);
    timeunit 1ns;
    timeprecision 1ps;
    // grant only while no other source holds the bus
    always_ff @(posedge clk)
    begin
        mem_rsp.ack <= !reset && mem_req.req && !stall && !mem_rsp.ack;
        mem_rsp.rdata <= (mem_req.req && !stall) ? mem_req.addr[15:0] ^ 16'ha5c3 : ~mem_rsp.rdata;
    end
endmodule : crcscn_arb_model

// ### testbench/tb_top.sv
// Self-checking bench for the CRC engine with memory scanner.
// Assumes the arbiter model crcscn_arb_model.
`define CHK(n, e, s) begin compares++; if ((e) !== (s)) begin failures++; $display("unexpected %s exp %h got %h", n, e, s); end end
module tb_top
    import crcscn_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, reset = 1, wb_cyc = 0, wb_stb = 0, wb_we = 0, wb_ack, scan_trig = 1, stall = 0, reg_sel = 0;
    logic [7:0] wb_adr = 8'h00;
    logic [3:0] wb_sel = 4'h0;
    logic [31:0] wb_wdat = 32'h0, wb_rdat, q, seed = 32'h22;
    logic [15:0] acc, poly, dat;
    int failures = 0, compares = 0, len;
    crcscn_mreq_t mem_req;
    crcscn_mrsp_t mem_rsp;
    crcscn_top dut (.clk(clk), .reset(reset), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr),
        .wb_wdat(wb_wdat), .wb_sel(wb_sel), .wb_ack(wb_ack), .wb_rdat(wb_rdat), .scan_trig(scan_trig),
        .mem_req(mem_req), .mem_rsp(mem_rsp));
    crcscn_arb_model arb (.clk(clk), .reset(reset), .stall(stall), .mem_req(mem_req), .mem_rsp(mem_rsp));
    always #4 clk = ~clk;
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    // Shift-register reference; zeros appended when augmenting
    function automatic logic [15:0] crc(input logic [15:0] a, input logic [15:0] d, input int aug, input int lsb,
        input int n);
        logic fb;
        for (int i = 0; i < n + (aug ? 16 : 0); i++)
        begin
            fb = a[15];
            a = {a[14:0], i < n ? d[lsb ? i : n - 1 - i] : 1'b0};
            if (fb)
                a ^= poly | 16'h0001;
        end
        return lsb ? {<<{a}} : a;
    endfunction : crc
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        wb_cyc <= 1;
        wb_stb <= 1;
        wb_we <= w;
        wb_adr <= a;
        wb_wdat <= d;
        wb_sel <= 4'hf;
        do
            @(posedge clk);
        while (wb_ack !== 1'b1);
        q = wb_rdat;
        wb_cyc <= 0;
        wb_stb <= 0;
        @(posedge clk);
    endtask : wb
    task automatic poll(input logic [7:0] a, input int b);
        do
            wb(0, a, 0);
        while (q[b] !== 1'b0);
    endtask : poll
    task automatic complete_run();
        $display("failures %0d compares %0d", failures, compares);
        if (failures == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : complete_run
    always @(posedge clk)
    begin
        stall <= xs() % 3 == 0;
        scan_trig <= xs() % 2 == 0;
        if (mem_req.req) `CHK("region", reg_sel, mem_req.eeprom);
    end
    initial
    begin
        #(8 * 90000);
        failures++;
        complete_run();
    end
    initial
    begin
        repeat (16) @(posedge clk);
        reset <= 0;
        @(posedge clk);
        wb(0, CRCSCN_ADR_POLY_LO, 0);
        `CHK("poly_lo", 32'h1, q)
        wb(1, CRCSCN_ADR_SHIFT_LO, 32'hff);
        wb(0, CRCSCN_ADR_SHIFT_LO, 0);
        `CHK("shift_lo", 32'h0, q)
        wb(0, 8'h3c, 0);
        `CHK("unmapped", 32'h0, q)
        for (int m = 0; m < 4; m++)
        begin
            poly = xs();
            dat = xs();
            len = m == 0 ? 0 : xs() % 16;
            wb(1, CRCSCN_ADR_LEN_CFG, len << 4 | 32'hf);
            wb(1, CRCSCN_ADR_POLY_HI, poly[15:8]);
            wb(1, CRCSCN_ADR_POLY_LO, poly[7:0]);
            wb(1, CRCSCN_ADR_ACC_HI, 0);
            wb(1, CRCSCN_ADR_ACC_LO, 0);
            wb(1, CRCSCN_ADR_CTRL_A, 32'hc0 | m[1] << 4 | m[0] << 1);
            wb(1, CRCSCN_ADR_DATA_HI, dat[15:8]);
            wb(1, CRCSCN_ADR_DATA_LO, dat[7:0]);
            wb(0, CRCSCN_ADR_CTRL_A, 0);
            `CHK("busy", 1'b1, q[5])
            poll(CRCSCN_ADR_CTRL_A, 5);
            acc = crc(0, dat, m[1], m[0], len + 1);
            wb(0, CRCSCN_ADR_ACC_LO, 0);
            `CHK("acc_lo", acc[7:0], q[7:0])
            wb(0, CRCSCN_ADR_ACC_HI, 0);
            `CHK("acc_hi", acc[15:8], q[7:0])
            wb(0, CRCSCN_ADR_FLAGS, 0);
            `CHK("crc_flag", 1'b1, q[0])
            wb(1, CRCSCN_ADR_FLAGS, 32'h3);
        end
        for (int s = 0; s < 3; s++)
        begin
            reg_sel <= s[0];
            wb(1, CRCSCN_ADR_ACC_HI, 0);
            wb(1, CRCSCN_ADR_ACC_LO, 0);
            wb(1, CRCSCN_ADR_CTRL_A, 32'hc0);
            wb(1, CRCSCN_ADR_SCAN_CUR, 32'h10 * s);
            wb(1, CRCSCN_ADR_SCAN_END, 32'h10 * s + 3);
            wb(1, CRCSCN_ADR_SCAN_CTRL, 32'ha0 | (s == 1 ? 32'h46 : 32'h20 * s));
            poll(CRCSCN_ADR_SCAN_CTRL, 5);
            `CHK("scan_busy", 1'b0, q[0])
            poll(CRCSCN_ADR_CTRL_A, 5);
            acc = 0;
            for (int k = 0; k < 4; k++)
                acc = crc(acc, (16'h10 * s + k) ^ 16'ha5c3, 0, 0, len + 1);
            wb(0, CRCSCN_ADR_ACC_LO, 0);
            `CHK("scan_acc", acc[7:0], q[7:0])
            wb(0, CRCSCN_ADR_SCAN_CUR, 0);
            `CHK("scan_cur", 32'h10 * s + 4, q)
            wb(0, CRCSCN_ADR_FLAGS, 0);
            `CHK("scan_flag", 1'b1, q[1])
            wb(1, CRCSCN_ADR_FLAGS, 32'h3);
        end
        wb(1, CRCSCN_ADR_SCAN_CUR, 0);
        wb(1, CRCSCN_ADR_SCAN_CTRL, 32'ha0);
        wb(1, CRCSCN_ADR_SCAN_CTRL, 32'h80);
        wb(0, CRCSCN_ADR_SCAN_CTRL, 0);
        `CHK("scan_stop", 1'b0, q[5])
        poll(CRCSCN_ADR_CTRL_A, 5);
        complete_run();
    end
endmodule : tb_top

// ### verilog/crcscn_pkg.sv
// Package for the CRC engine with memory scanner: register map, field positions,
// reset values and the carriers of the memory arbiter link.
// Assumes one system clock shared by the engine, the bus and the memory arbiter.
package crcscn_pkg;

    // --------------------------------------------------------------
    // Register byte addresses (one aligned 32-bit word each)
    // --------------------------------------------------------------
    localparam logic [7:0] CRCSCN_ADR_CTRL_A = 8'h00;
    localparam logic [7:0] CRCSCN_ADR_LEN_CFG = 8'h04;
    localparam logic [7:0] CRCSCN_ADR_DATA_HI = 8'h08;
    localparam logic [7:0] CRCSCN_ADR_DATA_LO = 8'h0c;
    localparam logic [7:0] CRCSCN_ADR_ACC_HI = 8'h10;
    localparam logic [7:0] CRCSCN_ADR_ACC_LO = 8'h14;
    localparam logic [7:0] CRCSCN_ADR_SHIFT_HI = 8'h18;
    localparam logic [7:0] CRCSCN_ADR_SHIFT_LO = 8'h1c;
    localparam logic [7:0] CRCSCN_ADR_POLY_HI = 8'h20;
    localparam logic [7:0] CRCSCN_ADR_POLY_LO = 8'h24;
    localparam logic [7:0] CRCSCN_ADR_SCAN_CTRL = 8'h28;
    localparam logic [7:0] CRCSCN_ADR_SCAN_CUR = 8'h2c;
    localparam logic [7:0] CRCSCN_ADR_SCAN_END = 8'h30;
    localparam logic [7:0] CRCSCN_ADR_FLAGS = 8'h34;

    // --------------------------------------------------------------
    // Field positions
    // --------------------------------------------------------------
    localparam int CRCSCN_B_ON = 7;
    localparam int CRCSCN_B_RUN = 6;
    localparam int CRCSCN_B_BUSY = 5;
    localparam int CRCSCN_B_ZAUG = 4;
    localparam int CRCSCN_B_LSB = 1;
    localparam int CRCSCN_B_FULL = 0;
    localparam int CRCSCN_B_SEN = 7;
    localparam int CRCSCN_B_STRIG = 6;
    localparam int CRCSCN_B_SGO = 5;
    localparam int CRCSCN_B_SREG = 2;
    localparam int CRCSCN_B_SBURST = 1;
    localparam int CRCSCN_B_SBUSY = 0;
    localparam int CRCSCN_B_CRC_FLAG = 0;
    localparam int CRCSCN_B_SCAN_FLAG = 1;

    // --------------------------------------------------------------
    // Widths and reset values
    // --------------------------------------------------------------
    localparam int CRCSCN_AW = 22;
    localparam logic [21:0] CRCSCN_CUR_RST = 22'h000000;
    localparam logic [21:0] CRCSCN_END_RST = 22'h3fffff;
    localparam logic [15:0] CRCSCN_POLY_RST = 16'h0001;
    localparam logic [7:0] CRCSCN_BYTE_RST = 8'h00;

    // --------------------------------------------------------------
    // Memory arbiter link
    // --------------------------------------------------------------
    typedef struct packed {
        logic req;
        logic eeprom;
        logic [21:0] addr;
    } crcscn_mreq_t;

    typedef struct packed {
        logic ack;
        logic [15:0] rdata;
    } crcscn_mrsp_t;

    typedef enum logic [1:0] {
        CRCSCN_IDLE = 2'b01,
        CRCSCN_SHIFT = 2'b10
    } crcscn_state_t;

endpackage : crcscn_pkg

// ### verilog/crcscn_top.sv
// CRC engine with memory scanner: Wishbone register slave, serial CRC shifter,
// accumulator and scanner that fetches words through the system memory arbiter.
// Assumes a classic Wishbone master and an arbiter on clk; scan_trig is asynchronous.
//
// Behaviour
// - Control enable bit 7 turns the CRC engine on; cleared keeps it idle.
// - Go bit 6 set runs the serial shifter; cleared stops it.
// - Busy bit 5 reads one while a shift runs or a word waits.
// - Zero-augment bit 4 appends polynomial-length zeros; clear appends none.
// - Bit 1 set shifts right LSb first; clear shifts left MSb first.
// - Full bit 0 reads one until the held word moves into the shifter.
// - Bits 7..4 hold word length minus one, the shifts per word.
// - Bits 3..0 hold polynomial length minus one.
// - Writing the low data byte loads the word and starts processing.
// - Shifter registers are read-only, reset to zero, read current shifter.
// - Polynomial bits 15..1 enable feedback terms; low bit 0 reads one.
// - Scanner enable bit changes no other register.
// - Plain mode requests memory only when the CRC can take data.
// - Trigger mode requests only when CRC can take data and trigger true.
// - Burst mode holds the memory request asserted whatever the trigger.
// - Scanner fetches and passes words only while its go bit is set.
// - Hardware clears scan go past end address, or when CRC go clears.
// - Software may clear scan go at any time to stop scanning.
// - Region bit 2 selects data EEPROM when set, program flash when clear.
// - Scanner busy bit 0 reads one while a scanner cycle is in progress.
// - CRC done flag sets on each busy fall; only software clears it.
// - Scan address increments per fetch; done flag sets past end address.
module crcscn_top
    import crcscn_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_we,
    input wire logic [7:0] wb_adr,
    input wire logic [31:0] wb_wdat,
    input wire logic [3:0] wb_sel,
    output logic wb_ack,
    output logic [31:0] wb_rdat,
    input wire logic scan_trig,
    output crcscn_mreq_t mem_req,
    input wire crcscn_mrsp_t mem_rsp
);

    // --------------------------------------------------------------
    // Register state
    // --------------------------------------------------------------
    logic ack_ff;
    logic [31:0] rdat_ff;
    logic crc_on_bit_ff, crc_run_bit_ff, zero_augment_mode_ff, lsb_first_select_ff;
    logic [3:0] word_length_field_ff, poly_length_field_ff;
    logic [15:0] data_ff, acc_ff, shift_ff;
    logic [15:1] poly_ff;
    logic full_ff;
    crcscn_state_t state_ff, nxt_state;
    logic [4:0] data_left_ff, zero_left_ff;
    logic busy_q_ff, crc_done_flag_ff, scan_done_flag_ff;
    logic scan_en_ff, scan_trigger_enable_ff, scan_go_ff, scan_region_select_ff, scan_burst_mode_ff;
    logic [21:0] scan_current_address_ff, scan_end_address_ff;
    logic req_ff, trig_meta_ff, trig_sync_ff;

    // --------------------------------------------------------------
    // Bus decode
    // --------------------------------------------------------------
    wire bus_req = wb_cyc & wb_stb;
    wire wr_fire = bus_req & wb_we & ack_ff & wb_sel[0];
    wire [7:0] adr_w = {wb_adr[7:2], 2'b00};
    wire [7:0] wb_b = wb_wdat[7:0];
    wire wr_ctrl = wr_fire & (adr_w == CRCSCN_ADR_CTRL_A);
    wire wr_len = wr_fire & (adr_w == CRCSCN_ADR_LEN_CFG);
    wire wr_dath = wr_fire & (adr_w == CRCSCN_ADR_DATA_HI);
    wire wr_datl = wr_fire & (adr_w == CRCSCN_ADR_DATA_LO);
    wire wr_acch = wr_fire & (adr_w == CRCSCN_ADR_ACC_HI);
    wire wr_accl = wr_fire & (adr_w == CRCSCN_ADR_ACC_LO);
    wire wr_polh = wr_fire & (adr_w == CRCSCN_ADR_POLY_HI);
    wire wr_poll = wr_fire & (adr_w == CRCSCN_ADR_POLY_LO);
    wire wr_scan = wr_fire & (adr_w == CRCSCN_ADR_SCAN_CTRL);
    wire wr_cur = wr_fire & (adr_w == CRCSCN_ADR_SCAN_CUR);
    wire wr_end = wr_fire & (adr_w == CRCSCN_ADR_SCAN_END);
    wire wr_flags = wr_fire & (adr_w == CRCSCN_ADR_FLAGS);

    // --------------------------------------------------------------
    // CRC datapath
    // --------------------------------------------------------------
    // engine gating
    wire crc_active = crc_on_bit_ff & crc_run_bit_ff;
    wire shifting = (state_ff == CRCSCN_SHIFT);
    wire crc_busy = full_ff | shifting;
    wire load = crc_active & full_ff & ~shifting;
    wire step = crc_active & shifting;
    wire last_step = step & ((5'(data_left_ff + zero_left_ff)) == 5'h01);
    wire in_bit = (data_left_ff != 5'h00) &
                  (lsb_first_select_ff ? shift_ff[0] : shift_ff[word_length_field_ff]);
    wire [15:0] poly_f = {poly_ff, 1'b1};
    logic [15:0] mask, poly_m, poly_rev, acc_step, base;
    logic fb;
    int j;

    // polynomial width mask and reflected terms
    always_comb
    begin
        j = 0;
        for (int i = 0; i < 16; i++)
        begin
            j = int'(poly_length_field_ff) - i;
            mask[i] = (i <= int'(poly_length_field_ff));
            poly_m[i] = mask[i] & poly_f[i];
            poly_rev[i] = (j >= 0) ? poly_f[j[3:0]] : 1'b0;
        end
    end

    // data enters at the low end MSb first, at the top polynomial bit LSb first
    always_comb
    begin
        if (lsb_first_select_ff)
        begin
            fb = acc_ff[0];
            base = (acc_ff >> 1) | (16'(in_bit) << poly_length_field_ff);
            acc_step = fb ? (base ^ poly_rev) : base;
        end
        else
        begin
            fb = acc_ff[poly_length_field_ff];
            base = ((acc_ff << 1) | 16'(in_bit)) & mask;
            acc_step = fb ? (base ^ poly_m) : base;
        end
    end

    // one bit per clock, then idle
    always_comb
    begin
        case (state_ff)
            CRCSCN_IDLE: nxt_state = load ? CRCSCN_SHIFT : CRCSCN_IDLE;
            CRCSCN_SHIFT: nxt_state = (last_step | ~crc_on_bit_ff) ? CRCSCN_IDLE : CRCSCN_SHIFT;
            default: nxt_state = CRCSCN_IDLE;
        endcase
    end

    // --------------------------------------------------------------
    // Scanner
    // --------------------------------------------------------------
    wire scan_active = scan_en_ff & scan_go_ff;
    wire fetch_ok = mem_rsp.ack & req_ff & ~full_ff & scan_active;
    wire [21:0] nxt_cur = fetch_ok ? 22'(scan_current_address_ff + 22'h000001)
                                   : scan_current_address_ff;
    wire past_end = scan_current_address_ff > scan_end_address_ff;
    wire nxt_past_end = nxt_cur > scan_end_address_ff;
    wire end_stop = scan_go_ff & past_end & ~req_ff;
    wire go_hw_clr = end_stop | ~crc_active;
    // plain mode waits for CRC room
    // trigger mode also waits for trigger
    wire req_start = scan_active & ~full_ff & ~nxt_past_end & (~scan_trigger_enable_ff | trig_sync_ff);
    logic nxt_req;

    always_comb
    begin
        if (~scan_active | ~crc_active)
            nxt_req = 1'b0;
        else if (scan_burst_mode_ff)
            nxt_req = ~nxt_past_end;
        else if (req_ff)
            nxt_req = ~fetch_ok;
        else
            nxt_req = req_start;
    end

    // --------------------------------------------------------------
    // Read mux
    // --------------------------------------------------------------
    wire [7:0] ctrl_rd = {crc_on_bit_ff, crc_run_bit_ff, crc_busy, zero_augment_mode_ff,
                          2'b00, lsb_first_select_ff, full_ff};
    wire [7:0] scan_rd = {scan_en_ff, scan_trigger_enable_ff, scan_go_ff, 2'b00,
                          scan_region_select_ff, scan_burst_mode_ff, req_ff};
    logic [31:0] rd_word;

    always_comb
    begin
        case (adr_w)
            CRCSCN_ADR_CTRL_A: rd_word = {24'h000000, ctrl_rd};
            CRCSCN_ADR_LEN_CFG: rd_word = {24'h000000, word_length_field_ff, poly_length_field_ff};
            CRCSCN_ADR_DATA_HI: rd_word = {24'h000000, data_ff[15:8]};
            CRCSCN_ADR_DATA_LO: rd_word = {24'h000000, data_ff[7:0]};
            CRCSCN_ADR_ACC_HI: rd_word = {24'h000000, acc_ff[15:8]};
            CRCSCN_ADR_ACC_LO: rd_word = {24'h000000, acc_ff[7:0]};
            CRCSCN_ADR_SHIFT_HI: rd_word = {24'h000000, shift_ff[15:8]};
            CRCSCN_ADR_SHIFT_LO: rd_word = {24'h000000, shift_ff[7:0]};
            CRCSCN_ADR_POLY_HI: rd_word = {24'h000000, poly_ff[15:8]};
            CRCSCN_ADR_POLY_LO: rd_word = {24'h000000, poly_ff[7:1], 1'b1};
            CRCSCN_ADR_SCAN_CTRL: rd_word = {24'h000000, scan_rd};
            CRCSCN_ADR_SCAN_CUR: rd_word = {10'h000, scan_current_address_ff};
            CRCSCN_ADR_SCAN_END: rd_word = {10'h000, scan_end_address_ff};
            CRCSCN_ADR_FLAGS: rd_word = {30'h00000000, scan_done_flag_ff, crc_done_flag_ff};
            default: rd_word = 32'h00000000;
        endcase
    end

    // --------------------------------------------------------------
    // Bus slave
    // --------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            ack_ff <= 1'b0;
            rdat_ff <= 32'h00000000;
        end
        else
        begin
            ack_ff <= bus_req & ~ack_ff;
            rdat_ff <= (bus_req & ~ack_ff) ? rd_word : rdat_ff;
        end
    end

    // --------------------------------------------------------------
    // Control registers
    // --------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            crc_on_bit_ff <= 1'b0;
            crc_run_bit_ff <= 1'b0;
            zero_augment_mode_ff <= 1'b0;
            lsb_first_select_ff <= 1'b0;
            word_length_field_ff <= 4'h0;
            poly_length_field_ff <= 4'h0;
            poly_ff <= CRCSCN_POLY_RST[15:1];
        end
        else
        begin
            if (wr_ctrl)
            begin
                crc_on_bit_ff <= wb_b[CRCSCN_B_ON];
                crc_run_bit_ff <= wb_b[CRCSCN_B_RUN];
                zero_augment_mode_ff <= wb_b[CRCSCN_B_ZAUG];
                lsb_first_select_ff <= wb_b[CRCSCN_B_LSB];
            end
            if (wr_len)
            begin
                word_length_field_ff <= wb_b[7:4];
                poly_length_field_ff <= wb_b[3:0];
            end
            if (wr_polh)
                poly_ff[15:8] <= wb_b;
            if (wr_poll)
                poly_ff[7:1] <= wb_b[7:1];
        end
    end

    // --------------------------------------------------------------
    // Data path registers
    // --------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            data_ff <= {CRCSCN_BYTE_RST, CRCSCN_BYTE_RST};
            full_ff <= 1'b0;
            acc_ff <= {CRCSCN_BYTE_RST, CRCSCN_BYTE_RST};
            shift_ff <= {CRCSCN_BYTE_RST, CRCSCN_BYTE_RST};
            state_ff <= CRCSCN_IDLE;
            data_left_ff <= 5'h00;
            zero_left_ff <= 5'h00;
            busy_q_ff <= 1'b0;
            crc_done_flag_ff <= 1'b0;
        end
        else
        begin
            if (wr_dath)
                data_ff[15:8] <= wb_b;
            // low byte write loads the word
            if (wr_datl)
                data_ff[7:0] <= wb_b;
            else if (fetch_ok)
                data_ff <= mem_rsp.rdata;
            // full set wins over the load
            full_ff <= wr_datl | fetch_ok | (full_ff & ~load);
            state_ff <= nxt_state;
            // counts of data and zero shifts
            if (load)
            begin
                shift_ff <= data_ff;
                data_left_ff <= 5'(word_length_field_ff) + 5'h01;
                zero_left_ff <= zero_augment_mode_ff ? (5'(poly_length_field_ff) + 5'h01) : 5'h00;
            end
            else if (step)
            begin
                shift_ff <= lsb_first_select_ff ? (shift_ff >> 1) : (shift_ff << 1);
                if (data_left_ff != 5'h00)
                    data_left_ff <= data_left_ff - 5'h01;
                else
                    zero_left_ff <= zero_left_ff - 5'h01;
            end
            if (step)
                acc_ff <= acc_step;
            else if (wr_acch)
                acc_ff[15:8] <= wb_b;
            else if (wr_accl)
                acc_ff[7:0] <= wb_b;
            busy_q_ff <= crc_busy;
            // set on busy fall wins over clear
            crc_done_flag_ff <= (busy_q_ff & ~crc_busy) |
                                (crc_done_flag_ff & ~(wr_flags & wb_b[CRCSCN_B_CRC_FLAG]));
        end
    end

    // --------------------------------------------------------------
    // Scanner registers
    // --------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            scan_en_ff <= 1'b0;
            scan_trigger_enable_ff <= 1'b0;
            scan_go_ff <= 1'b0;
            scan_region_select_ff <= 1'b0;
            scan_burst_mode_ff <= 1'b0;
            scan_current_address_ff <= CRCSCN_CUR_RST;
            scan_end_address_ff <= CRCSCN_END_RST;
            scan_done_flag_ff <= 1'b0;
            req_ff <= 1'b0;
            trig_meta_ff <= 1'b0;
            trig_sync_ff <= 1'b0;
        end
        else
        begin
            trig_meta_ff <= scan_trig;
            trig_sync_ff <= trig_meta_ff;
            // enable touches only its own bit
            if (wr_scan)
            begin
                scan_en_ff <= wb_b[CRCSCN_B_SEN];
                scan_trigger_enable_ff <= wb_b[CRCSCN_B_STRIG];
                scan_region_select_ff <= wb_b[CRCSCN_B_SREG];
                scan_burst_mode_ff <= wb_b[CRCSCN_B_SBURST];
            end
            if (go_hw_clr)
                scan_go_ff <= 1'b0;
            else if (wr_scan)
                scan_go_ff <= wb_b[CRCSCN_B_SGO];
            // increment per fetch, writes ignored while scanning
            if (wr_cur & ~scan_go_ff)
                scan_current_address_ff <= wb_wdat[21:0];
            else
                scan_current_address_ff <= nxt_cur;
            if (wr_end & ~scan_go_ff)
                scan_end_address_ff <= wb_wdat[21:0];
            scan_done_flag_ff <= end_stop |
                                 (scan_done_flag_ff & ~(wr_flags & wb_b[CRCSCN_B_SCAN_FLAG]));
            // busy while a request is outstanding
            req_ff <= nxt_req;
        end
    end

    assign wb_ack = ack_ff;
    assign wb_rdat = rdat_ff;
    assign mem_req = '{req: req_ff, eeprom: scan_region_select_ff, addr: scan_current_address_ff};

    // --------------------------------------------------------------
    // Assertions
    // --------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence s_load_seen;
        load ##1 shifting;
    endsequence
    sequence s_burst_steady;
        (scan_burst_mode_ff & scan_active & crc_active & ~past_end & ~fetch_ok) [*2];
    endsequence

    property p_on_gate;
        $rose(shifting) |-> $past(crc_on_bit_ff & crc_run_bit_ff);
    endproperty
    a_on_gate: assert property (p_on_gate) else $error("shift started while engine off");
    property p_go_halts;
        (shifting & ~crc_run_bit_ff) |=> acc_ff == $past(acc_ff) || $past(wr_acch | wr_accl);
    endproperty
    a_go_halts: assert property (p_go_halts) else $error("accumulator moved with go clear");
    property p_done_flag;
        $fell(crc_busy) |=> crc_done_flag_ff;
    endproperty
    a_done_flag: assert property (p_done_flag) else $error("done flag missed busy fall");
    property p_full_moves;
        (load & ~wr_datl & ~fetch_ok) |=> ~full_ff && shift_ff == $past(data_ff);
    endproperty
    a_full_moves: assert property (p_full_moves) else $error("word did not move to shifter");
    property p_one_bit_word;
        (load & word_length_field_ff == 4'h0 & ~zero_augment_mode_ff & crc_run_bit_ff) |->
            s_load_seen ##1 ~shifting;
    endproperty
    a_one_bit_word: assert property (p_one_bit_word) else $error("single bit word took wrong time");
    property p_poly_bit0;
        (bus_req & ~ack_ff & ~wb_we & adr_w == CRCSCN_ADR_POLY_LO) |=> wb_ack && wb_rdat[0];
    endproperty
    a_poly_bit0: assert property (p_poly_bit0) else $error("polynomial bit 0 not one");
    property p_burst_req;
        s_burst_steady |=> mem_req.req;
    endproperty
    a_burst_req: assert property (p_burst_req) else $error("burst request dropped");
    property p_run_clear_stops;
        ~crc_run_bit_ff |=> ~scan_go_ff;
    endproperty
    a_run_clear_stops: assert property (p_run_clear_stops) else $error("scan go survived go clear");
    property p_trig_req;
        ($rose(req_ff) & ~scan_burst_mode_ff & scan_trigger_enable_ff) |-> $past(trig_sync_ff & ~full_ff);
    endproperty
    a_trig_req: assert property (p_trig_req) else $error("request without trigger");
    property p_addr_inc;
        fetch_ok & ~wr_cur |=> scan_current_address_ff == 22'($past(scan_current_address_ff) + 22'h000001);
    endproperty
    a_addr_inc: assert property (p_addr_inc) else $error("scan address not incremented");
    property p_region;
        wr_scan |=> mem_req.eeprom == $past(wb_b[CRCSCN_B_SREG]);
    endproperty
    a_region: assert property (p_region) else $error("region select not driven");

endmodule : crcscn_top
